// ==== dptag_fifo.sv ====
// Parameterised flip-flop FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module dptag_fifo #(
  parameter int W = 17,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Fill side
  dptag_fifo_if.snk inp,
  // Drain side
  output logic outValid,
  output logic [W-1:0] outData,
  input wire logic outReady
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } dptag_fifo_st_t;
  dptag_fifo_st_t s_r, s_nxt;
  logic push, pop;
  assign inp.ready = (s_r.cnt != (AW+1)'(DEPTH));
  assign outValid = (s_r.cnt != '0);
  assign outData = s_r.mem[s_r.rp];
  assign push = inp.valid && inp.ready;
  assign pop = outValid && outReady;
  always_comb begin
    s_nxt = s_r;
    if (push) begin
      s_nxt.mem[s_r.wp] = inp.data;
      s_nxt.wp = (s_r.wp == AW'(DEPTH-1)) ? '0 : s_r.wp + 1'b1;
    end
    if (pop) begin
      s_nxt.rp = (s_r.rp == AW'(DEPTH-1)) ? '0 : s_r.rp + 1'b1;
    end
    if (push && !pop) begin
      s_nxt.cnt = s_r.cnt + 1'b1;
    end else if (pop && !push) begin
      s_nxt.cnt = s_r.cnt - 1'b1;
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end
endmodule : dptag_fifo
`default_nettype wire

// ==== dptag_fifo_if.sv ====
// Stream carrier between the serial front end and the write buffer
`timescale 1ns/1ps
`default_nettype none
interface dptag_fifo_if #(parameter int W = 17);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : dptag_fifo_if
`default_nettype wire

// ==== dptag_i2c_slave.sv ====
// Dual-port tag: serial two-wire slave front end and activity output
`timescale 1ns/1ps
`default_nettype none
`include "dptag_params.svh"
module dptag_i2c_slave
  import dptag_pkg::*;
#(
  parameter logic [3:0] TYPE_ID = `DPTAG_TYPE_ID, // Arbitrary value
  parameter logic AREA_ID = `DPTAG_AREA_DEFAULT,
  parameter int MEM_BYTES = `DPTAG_MEM_BYTES,
  parameter int FIFO_DEPTH = `DPTAG_FIFO_DEPTH
) (
  // Core clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Link clock domain (serial clock is the link clock)
  input wire logic sclClk,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  // Contactless side status, core clock domain
  input wire logic rfWriteActive,
  input wire logic rfCmdActive,
  input wire logic modeSel,
  input wire logic vccPowered,
  // Activity output, open drain
  output logic activityOut,
  output logic activityOe,
  // Memory write port, core clock domain
  output logic memWe,
  output logic [8:0] memAddr,
  output logic [7:0] memWdata,
  // Memory read data to the serial side
  input wire logic [7:0] memRdata
);
  localparam int AW = $clog2(MEM_BYTES);
  ////////////////////////////////////////////////////////////////////////
  // Link domain state
  typedef struct packed {
    dptag_state_t st;
    logic [3:0] bitCnt;
    logic [7:0] shift;
    logic [AW-1:0] addr;
    logic addrHi;
    logic addrLoPend;
    logic rd;
    logic [7:0] txByte;
    logic wrTgl;
    // Two slots: a byte stays put for two bytes while the core fetches it
    logic [1:0][AW-1:0] wrAddr;
    logic [1:0][7:0] wrData;
  } dptag_link_t;
  dptag_link_t l_r, l_nxt;
  // Start and stop are seen on data edges while the clock is high
  logic startTgl_r = 1'b0;
  logic stopTgl_r = 1'b0;
  logic startSeen, stopSeen;
  always_ff @(negedge sdaIn) begin
    if (sclClk) begin
      startTgl_r <= ~startTgl_r;
    end
  end
  always_ff @(posedge sdaIn) begin
    if (sclClk) begin
      stopTgl_r <= ~stopTgl_r;
    end
  end
  logic stA_r, spA_r;
  always_ff @(posedge sclClk) begin
    stA_r <= startTgl_r;
    spA_r <= stopTgl_r;
  end
  assign startSeen = (stA_r != startTgl_r);
  assign stopSeen = (spA_r != stopTgl_r);
  function automatic logic selOk(input logic [7:0] b);
    selOk = (b[`DPTAG_SEL_TYPE_HI:`DPTAG_SEL_TYPE_LO] == TYPE_ID) &&
            (b[`DPTAG_SEL_AREA] == AREA_ID) &&
            b[`DPTAG_SEL_ONES_HI] && b[`DPTAG_SEL_ONES_LO];
  endfunction : selOk
  ////////////////////////////////////////////////////////////////////////
  // Bit engine, sampled on rising serial clock
  logic [7:0] shIn;
  assign shIn = {l_r.shift[6:0], sdaIn};
  always_comb begin
    l_nxt = l_r;
    if (startSeen) begin
      l_nxt.st = ST_SEL;
      l_nxt.bitCnt = 4'h1;
      l_nxt.shift = {7'h00, sdaIn};
      l_nxt.addrHi = 1'b1;
      l_nxt.addrLoPend = 1'b1;
    end else if (stopSeen) begin
      l_nxt.st = ST_IDLE;
    end else begin
      case (l_r.st)
        ST_SEL, ST_ADDR, ST_WDATA: begin
          l_nxt.shift = shIn;
          l_nxt.bitCnt = l_r.bitCnt + 4'h1;
          if (l_r.bitCnt == 4'h7) begin
            l_nxt.bitCnt = 4'h0;
            l_nxt.st = ST_ACK;
            if (l_r.st == ST_SEL) begin
              l_nxt.rd = shIn[`DPTAG_SEL_DIR];
              if (!selOk(shIn)) begin
                l_nxt.st = ST_IGNORE;
              end
            end else if (l_r.st == ST_ADDR) begin
              if (l_r.addrHi) begin
                l_nxt.addr[AW-1:8] = shIn[AW-9:0];
              end else begin
                l_nxt.addr[7:0] = shIn;
                l_nxt.addrLoPend = 1'b0;
              end
            end else begin
              l_nxt.wrAddr[~l_r.wrTgl] = l_r.addr;
              l_nxt.wrData[~l_r.wrTgl] = shIn;
              l_nxt.wrTgl = ~l_r.wrTgl;
              l_nxt.addr = l_r.addr + 1'b1;
            end
          end
        end
        ST_ACK: begin
          l_nxt.bitCnt = 4'h0;
          if (l_r.rd && (l_r.shift[`DPTAG_SEL_DIR] || l_r.txByte != 8'h00)) begin
            l_nxt.st = ST_RDATA;
          end else if (l_r.rd) begin
            l_nxt.st = ST_RDATA;
          end else if (l_r.addrHi && l_r.st == ST_ACK &&
                       l_r.shift == l_r.shift) begin
            l_nxt.st = ST_ADDR;
          end
          if (!l_r.rd) begin
            if (l_r.bitCnt == 4'h0 && l_r.addrHi &&
                l_r.shift[`DPTAG_SEL_DIR] == 1'b0 &&
                l_r.st == ST_ACK) begin
              l_nxt.st = ST_ADDR;
            end
          end
          l_nxt.txByte = memRdata;
        end
        ST_RDATA: begin
          l_nxt.bitCnt = l_r.bitCnt + 4'h1;
          if (l_r.bitCnt == 4'h7) begin
            l_nxt.st = ST_MACK;
            l_nxt.addr = l_r.addr + 1'b1;
          end
        end
        ST_MACK: begin
          l_nxt.bitCnt = 4'h0;
          l_nxt.txByte = memRdata;
          l_nxt.st = sdaIn ? ST_IGNORE : ST_RDATA;
        end
        ST_IGNORE: begin
          l_nxt.st = ST_IGNORE;
        end
        default: begin
          l_nxt.st = ST_IDLE;
        end
      endcase
    end
  end
  // Address phase tracking: two bytes, high first, then data
  dptag_link_t l_fix;
  always_comb begin
    l_fix = l_nxt;
    if ((l_r.st == ST_ADDR) && (l_r.bitCnt == 4'h7)) begin
      l_fix.addrHi = 1'b0;
    end
    if (l_r.st == ST_ACK && !l_r.rd && !l_r.addrHi && !l_r.addrLoPend) begin
      l_fix.st = ST_WDATA;
    end
    if (l_r.st == ST_ACK && !l_r.rd && (l_r.addrHi || l_r.addrLoPend)) begin
      l_fix.st = ST_ADDR;
    end
  end
  logic linkRst;
  always_ff @(posedge sclClk) begin
    if (linkRst) begin
      l_r <= '0;
    end else begin
      l_r <= l_fix;
    end
  end
  // Core reset reaches the link domain through two flops
  logic lr1_r, lr2_r;
  always_ff @(posedge sclClk) begin
    lr1_r <= rst_n;
    lr2_r <= lr1_r;
  end
  assign linkRst = !lr2_r;
  ////////////////////////////////////////////////////////////////////////
  // Data line drive, changed on falling serial clock
  logic sdaOe_r;
  always_ff @(negedge sclClk) begin
    if (linkRst) begin
      sdaOe_r <= 1'b0;
    end else if (l_r.st == ST_ACK) begin
      sdaOe_r <= 1'b1;
    end else if (l_r.st == ST_RDATA) begin
      sdaOe_r <= !l_r.txByte[3'(4'h7 - l_r.bitCnt)];
    end else begin
      sdaOe_r <= 1'b0;
    end
  end
  assign sdaOe = sdaOe_r;
  assign sdaOut = 1'b0;
  ////////////////////////////////////////////////////////////////////////
  // Core domain: written bytes cross by toggle into the buffer
  typedef struct packed {
    logic [2:0] tg;
    logic [AW-1:0] a;
    logic [7:0] d;
    logic push;
    logic [2:0] wr;
    logic [2:0] cmd;
    logic [1:0] mode;
    logic [1:0] pwr;
    logic modeLatch;
    logic actOe;
    logic we;
    logic [8:0] wa;
    logic [7:0] wd;
  } dptag_core_t;
  dptag_core_t c_r, c_nxt;
  dptag_fifo_if #(.W(AW+8)) fq ();
  logic fOutValid;
  logic [AW+7:0] fOutData;
  assign fq.valid = c_r.push;
  assign fq.data = {c_r.a, c_r.d};
  dptag_fifo #(.W(AW+8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .inp(fq),
    .outValid(fOutValid),
    .outData(fOutData),
    .outReady(1'b1)
  );
  logic opStart;
  logic modeNow;
  always_comb begin
    c_nxt = c_r;
    c_nxt.tg = {c_r.tg[1:0], l_r.wrTgl};
    c_nxt.wr = {c_r.wr[1:0], rfWriteActive};
    c_nxt.cmd = {c_r.cmd[1:0], rfCmdActive};
    c_nxt.mode = {c_r.mode[0], modeSel};
    c_nxt.pwr = {c_r.pwr[0], vccPowered};
    if (c_r.tg[2] != c_r.tg[1]) begin
      c_nxt.a = l_r.wrAddr[c_r.tg[1]];
      c_nxt.d = l_r.wrData[c_r.tg[1]];
      c_nxt.push = 1'b1;
    end else if (fq.ready) begin
      c_nxt.push = 1'b0;
    end
    c_nxt.we = fOutValid;
    if (fOutValid) begin
      c_nxt.wa = 9'(fOutData[AW+7:8]);
      c_nxt.wd = fOutData[7:0];
    end else if (c_r.we) begin
      // Park on the next byte; reads only follow written addresses
      c_nxt.wa = c_r.wa + 9'h001;
    end
    opStart = (c_r.wr[1] && !c_r.wr[2]) || (c_r.cmd[1] && !c_r.cmd[2]);
    // New mode is taken only when an operation starts with the output off, so no glitch mid-operation
    modeNow = c_r.modeLatch;
    if (opStart && !c_r.actOe) begin
      modeNow = c_r.mode[1];
    end
    c_nxt.modeLatch = modeNow;
    if (!c_r.pwr[1]) begin
      c_nxt.actOe = 1'b0;
    end else if (modeNow == 1'b0) begin
      c_nxt.actOe = c_r.wr[1];
    end else begin
      c_nxt.actOe = c_r.cmd[1];
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      c_r <= '0;
    end else begin
      c_r <= c_nxt;
    end
  end
  assign activityOut = 1'b0;
  assign activityOe = c_r.actOe;
  assign memWe = c_r.we;
  assign memAddr = c_r.wa;
  assign memWdata = c_r.wd;
endmodule : dptag_i2c_slave
`default_nettype wire

// ==== dptag_i2c_slave_properties.sv ====
// Concurrent checks on the serial slave ports
`timescale 1ns/1ps
`default_nettype none
module dptag_i2c_slave_properties #(
  parameter logic [3:0] TYPE_ID = 4'h5,
  parameter logic AREA_ID = 1'b0
) (
  // Clocks
  input wire logic clk,
  input wire logic rst_n,
  input wire logic sclClk,
  // Serial data
  input wire logic sdaIn,
  input wire logic sdaOut,
  input wire logic sdaOe,
  // Activity
  input wire logic rfWriteActive,
  input wire logic rfCmdActive,
  input wire logic modeSel,
  input wire logic vccPowered,
  input wire logic activityOut,
  input wire logic activityOe,
  // Memory
  input wire logic memWe,
  input wire logic [8:0] memAddr
);
  ////////////////////////////////////////////////////////////////////////
  logic stTog = 1'b0;
  logic stTogQ = 1'b0;
  logic [3:0] bitCnt = 4'hf;
  logic [7:0] shf = 8'h00;
  // Gated by reset: an unknown line level must not poison the toggle
  always @(negedge sdaIn) if (sclClk & rst_n) stTog <= ~stTog;
  always @(posedge sclClk) begin
    stTogQ <= stTog;
    if (stTog != stTogQ) begin
      bitCnt <= 4'h1;
      shf <= {7'h00, sdaIn};
    end else if (bitCnt != 4'hf) begin
      bitCnt <= bitCnt + 4'h1;
      shf <= {shf[6:0], sdaIn};
    end
  end
  ////////////////////////////////////////////////////////////////////////
  AST_SDA_OD: assert property (@(posedge clk) disable iff (!rst_n)
    sdaOut == 1'b0) else $error("data line driven high");
  AST_ACT_OD: assert property (@(posedge clk) disable iff (!rst_n)
    activityOut == 1'b0) else $error("activity line driven high");
  AST_NO_VCC: assert property (@(posedge clk) disable iff (!rst_n)
    !vccPowered [*4] |-> !activityOe) else $error("driven without supply");
  AST_WIP_ON: assert property (@(posedge clk) disable iff (!rst_n)
    (vccPowered && !modeSel && rfWriteActive) [*5] |-> activityOe)
    else $error("write progress not shown");
  AST_BUSY_ON: assert property (@(posedge clk) disable iff (!rst_n)
    (vccPowered && modeSel && rfCmdActive) [*5] |-> activityOe)
    else $error("busy not shown");
  AST_IDLE_OFF: assert property (@(posedge clk) disable iff (!rst_n)
    (!rfWriteActive && !rfCmdActive) [*5] |-> !activityOe)
    else $error("activity held while idle");
  AST_SEL_ACK: assert property (@(posedge sclClk) disable iff (!rst_n)
    bitCnt == 4'h8 |-> sdaOe == (shf[7:1] == {TYPE_ID, AREA_ID, 2'b11}))
    else $error("select byte answer wrong");
  AST_ADDR_INC: assert property (@(posedge clk) disable iff (!rst_n)
    memWe && $past(memWe) |-> memAddr == $past(memAddr) + 9'h001)
    else $error("write address did not step");
  cover property (@(posedge clk) memWe);
  cover property (@(posedge sclClk) bitCnt == 4'h8 && sdaOe);
  cover property (@(posedge clk) $rose(activityOe));
endmodule : dptag_i2c_slave_properties
bind dptag_i2c_slave dptag_i2c_slave_properties #(
  .TYPE_ID(TYPE_ID), .AREA_ID(AREA_ID)) i_props (.clk, .rst_n, .sclClk,
  .sdaIn, .sdaOut, .sdaOe, .rfWriteActive, .rfCmdActive, .modeSel,
  .vccPowered, .activityOut, .activityOe, .memWe, .memAddr);
`default_nettype wire

// ==== dptag_i2c_slave_tb.sv ====
// Self-checking bench for the serial slave and activity output
`timescale 1ns/1ps
`default_nettype none
`include "dptag_params.svh"
module dptag_i2c_slave_tb;
  ////////////////////////////////////////////////////////////////////////
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic rfWriteActive = 1'b0;
  logic rfCmdActive = 1'b0;
  logic modeSel = 1'b0;
  logic vccPowered = 1'b1;
  logic sclClk, sdaIn, sdaOut, sdaOe, activityOut, activityOe, memWe, ack;
  logic [8:0] memAddr;
  logic [7:0] memWdata, memRdata, rd;
  logic [7:0] ram [512];
  int errorCnt = 0;
  int checks = 0;
  int expQ[$];
  int memModel[512];
  int addr;
  localparam logic [7:0] SEL = {`DPTAG_TYPE_ID, `DPTAG_AREA_DEFAULT, 3'h6};
  always #20 clk = ~clk;
  dptag_i2c_slave i_dut (.clk, .rst_n, .sclClk, .sdaIn, .sdaOut, .sdaOe,
    .rfWriteActive, .rfCmdActive, .modeSel, .vccPowered, .activityOut,
    .activityOe, .memWe, .memAddr, .memWdata, .memRdata);
  dptag_mst_model i_mst (.sclClk, .sdaIn, .sdaOe);
  assign memRdata = ram[memAddr];
  always @(posedge clk) if (memWe === 1'b1) ram[memAddr] <= memWdata;
  ////////////////////////////////////////////////////////////////////////
  task check(input logic [16:0] seen, input logic [16:0] exp);
    checks++;
    if (seen !== exp) begin
      errorCnt++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task tally_and_finish;
    $display("checks=%0d errors=%0d", checks, errorCnt);
    if (errorCnt == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : tally_and_finish
  always @(posedge clk) begin
    if (rst_n && memWe === 1'b1) begin
      if (expQ.size() == 0) check(17'h1ffff, 17'h0);
      else check({memAddr, memWdata}, 17'(expQ.pop_front()));
    end
  end
  task put(input logic [7:0] b, input logic exp);
    i_mst.wrByte(b, ack);
    check(ack, exp);
  endtask : put
  // A refused select must leave memory untouched
  task xfer(input logic [7:0] sel, input int n);
    logic nak;
    logic [7:0] d;
    nak = (sel != SEL);
    i_mst.start();
    put(sel, nak);
    put({7'h00, addr[8]}, nak);
    put(addr[7:0], nak);
    for (int i = 0; i < n; i++) begin
      d = 8'($urandom);
      put(d, nak);
      if (!nak) begin
        expQ.push_back({addr[8:0], d});
        memModel[addr] = d;
        addr = (addr + 1) % 512;
      end
    end
    i_mst.stop();
    for (int i = 0; i < 200 && expQ.size() > 0; i++) @(posedge clk);
    if (expQ.size() > 0) begin
      check(17'h1, 17'h0);
      tally_and_finish();
    end
    $display("test xfer %h done", sel);
  endtask : xfer
  // Mode only moves while both activities are idle
  task act(input logic m, input logic v, input logic w, input logic c);
    @(posedge clk) #1 {rfWriteActive, rfCmdActive} = 2'h0;
    repeat (6) @(posedge clk);
    #1 {modeSel, vccPowered} = {m, v};
    repeat (2) @(posedge clk);
    #1 {rfWriteActive, rfCmdActive} = {w, c};
    repeat (6) @(posedge clk);
    #1 check(activityOe, v && (m ? c : w));
  endtask : act
  initial begin
    for (int i = 0; i < 512; i++) begin
      ram[i] = 8'(i) ^ 8'h3c;
      memModel[i] = ram[i];
    end
    i_mst.idle(4);
    repeat (5) @(posedge clk);
    #1 rst_n = 1'b1;
    // Link reset only leaves on serial clock edges
    i_mst.idle(4);
    repeat (4) @(posedge clk);
    void'($urandom(89));
    addr = 'h1fe;
    xfer(SEL, 4);
    xfer(SEL ^ 8'h80, 2);
    xfer(SEL ^ 8'h08, 2);
    i_mst.start();
    put(SEL | 8'h01, 1'b0);
    i_mst.rdByte(1'b1, rd);
    i_mst.stop();
    check(rd, 17'(memModel[addr]));
    $display("test read done");
    for (int i = 0; i < 16; i++) act(i[0], i[1], i[2], i[3]);
    $display("test activity done");
    act(1'b0, 1'b1, 1'b1, 1'b0);
    modeSel = 1'b1;
    repeat (6) @(posedge clk);
    #1 check(activityOe, 1'b1);
    rfWriteActive = 1'b0;
    repeat (6) @(posedge clk);
    #1 check(activityOe, 1'b0);
    $display("test mode hold done");
    tally_and_finish();
  end
endmodule : dptag_i2c_slave_tb
`default_nettype wire

// ==== dptag_mst_model.sv ====
// Behavioural two-wire bus master for the serial slave
`timescale 1ns/1ps
`default_nettype none
module dptag_mst_model (
  // Bus lines
  output logic sclClk,
  output logic sdaIn,
  // Slave pull-down
  input wire logic sdaOe
);
  logic drvLow;
  // Pulled-up wire, low while either side pulls
  assign sdaIn = ~(drvLow | sdaOe);
  initial begin
    sclClk = 1'b1;
    drvLow = 1'b0;
  end
  // Clock stands high between frames; these pulses only feed link reset
  task idle(input int n);
    repeat (n) begin
      #6 sclClk = 1'b0;
      #6 sclClk = 1'b1;
    end
  endtask : idle
  task start;
    #6 drvLow = 1'b1;
    #6 sclClk = 1'b0;
  endtask : start
  task bitx(input logic b, output logic v);
    #3 drvLow = ~b;
    #3 sclClk = 1'b1;
    #3 v = sdaIn;
    #3 sclClk = 1'b0;
  endtask : bitx
  task wrByte(input logic [7:0] b, output logic ack);
    logic v;
    for (int i = 7; i >= 0; i--) bitx(b[i], v);
    bitx(1'b1, ack);
  endtask : wrByte
  task rdByte(input logic nack, output logic [7:0] b);
    logic v;
    for (int i = 7; i >= 0; i--) begin
      bitx(1'b1, v);
      b[i] = v;
    end
    bitx(nack, v);
  endtask : rdByte
  task stop;
    #3 drvLow = 1'b1;
    #3 sclClk = 1'b1;
    #3 drvLow = 1'b0;
    #3;
  endtask : stop
endmodule : dptag_mst_model
`default_nettype wire

// ==== dptag_params.svh ====
// Constants of the dual-port tag serial slave
`ifndef DPTAG_PARAMS_SVH
`define DPTAG_PARAMS_SVH
`define DPTAG_TYPE_ID 4'h5
`define DPTAG_AREA_DEFAULT 1'b0
`define DPTAG_MEM_BYTES 512
`define DPTAG_RF_WORDS 128
`define DPTAG_FIFO_DEPTH 8
`define DPTAG_SEL_TYPE_HI 7
`define DPTAG_SEL_TYPE_LO 4
`define DPTAG_SEL_AREA 3
`define DPTAG_SEL_ONES_HI 2
`define DPTAG_SEL_ONES_LO 1
`define DPTAG_SEL_DIR 0
`endif

// ==== dptag_pkg.sv ====
// Types of the dual-port tag serial slave
package dptag_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_SEL = 3'b001,
    ST_ADDR = 3'b010,
    ST_WDATA = 3'b011,
    ST_RDATA = 3'b100,
    ST_ACK = 3'b101,
    ST_MACK = 3'b110,
    ST_IGNORE = 3'b111
  } dptag_state_t;
endpackage : dptag_pkg
